//--- verilog/avmr_top.v
// Audio output back end: volume, register-fed mix-in with saturation, and
// a sample rate converter feeding registers. AHB-Lite slave, one clock.
// Assumes DAC samples arrive on hclk with a one-cycle valid strobe.
`timescale 1ns/1ps
`include "avmr_map.vh"

module avmr_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire [23:0] dac_left_in,
  input  wire [23:0] dac_right_in,
  input  wire        dac_in_valid,
  output reg  [19:0] dac_left_out,
  output reg  [19:0] dac_right_out,
  output reg         dac_out_valid,
  output reg         mix_in_irq,
  output reg         resampler_irq
);

  // Fine gain coefficient in Q2.14, 10^(code/40); codes above 11 give unity
  // Coefficients are rounded to the nearest LSB of the Q2.14 scale, except code 5, which is one LSB high
  function [15:0] fine_coef;
    input [3:0] code;
    begin
      case (code)
        4'h1:    fine_coef = 16'h43cb;
        4'h2:    fine_coef = 16'h47cf;
        4'h3:    fine_coef = 16'h4c10;
        4'h4:    fine_coef = 16'h5092;
        4'h5:    fine_coef = 16'h5559;
        4'h6:    fine_coef = 16'h5a67;
        4'h7:    fine_coef = 16'h5fc2;
        4'h8:    fine_coef = 16'h656f;
        4'h9:    fine_coef = 16'h6b72;
        4'ha:    fine_coef = 16'h71cf;
        4'hb:    fine_coef = 16'h788e;
        default: fine_coef = 16'h4000;
      endcase
    end
  endfunction

  // Volume stage: arithmetic shift per coarse unit, then fine multiply
  // Both steps round toward minus infinity, so a quiet signal settles one LSB low
  function [23:0] apply_volume;
    input [23:0] smp;
    input [3:0]  coarse;
    input [3:0]  fine;
    reg signed [23:0] shifted;
    reg signed [40:0] prod;
    begin
      shifted = $signed(smp) >>> coarse;
      prod = shifted * $signed({1'b0, fine_coef(fine)});
      prod = prod >>> 14;
      // Boost can exceed full scale, so clip rather than wrap
      if (prod > 41'sd8388607)
        apply_volume = 24'h7f_ffff;
      else if (prod < -41'sd8388608)
        apply_volume = 24'h80_0000;
      else
        apply_volume = prod[23:0];
    end
  endfunction

  // Saturating 20-bit signed add of DAC and mix-in samples
  function [19:0] sat_add20;
    input [19:0] a;
    input [19:0] b;
    reg [20:0] sum;
    begin
      sum = {a[19], a} + {b[19], b};
      // Overflow shows as disagreement between the two top sum bits
      if (sum[20] != sum[19])
        sat_add20 = sum[20] ? 20'h8_0000 : 20'h7_ffff;
      else
        sat_add20 = sum[19:0];
    end
  endfunction

  // Software-visible registers
  reg [15:0] volume_r;       // Coarse and fine fields per channel
  reg [11:0] mix_rate_r;     // Mix-in period minus one
  reg        mix_ena_r;      // Mix-in enable
  reg        mix_full_r;     // Both data words written, not yet taken
  reg        mix_urun_r;     // Sticky underrun
  reg [15:0] mix_l_lo_r;     // Left low nibble word
  reg [15:0] mix_l_hi_r;     // Left high word
  reg [15:0] mix_r_lo_r;     // Right low nibble word
  reg [15:0] mix_r_hi_r;     // Right high word
  reg        mix_l_wr_r;     // Left high written since full was last set
  reg        mix_r_wr_r;     // Right high written since full was last set
  reg [11:0] rsmp_rate_r;    // Resampler period field
  reg        rsmp_ena_r;     // Resampler enable
  reg        rsmp_lfull_r;   // Left output unread
  reg        rsmp_rfull_r;   // Right output unread
  reg        rsmp_orun_r;    // Sticky overrun
  reg [23:0] rsmp_l_out_r;   // Left output sample
  reg [23:0] rsmp_r_out_r;   // Right output sample

  // Internal datapath state
  reg [19:0] mix_l_cur_r;    // Mix-in sample being added, left
  reg [19:0] mix_r_cur_r;    // Mix-in sample being added, right
  reg [11:0] mix_cnt_r;      // Mix-in period counter
  reg [12:0] rsmp_cnt_r;     // Resampler period counter
  reg [4:0]  rsmp_seen_r;    // Input samples counted since enable
  reg [23:0] rsmp_l_hold_r;  // Latest input held for resampling, left
  reg [23:0] rsmp_r_hold_r;  // Latest input held for resampling, right

  // Bus data-phase state
  reg        wr_pend_r;      // A write address phase was accepted
  reg [15:0] wr_idx_r;       // Index of that write

  // Address phase decode
  // Bits above 17 are not decoded, so the map repeats every 256 KB
  // Transfer size is not checked; any write stores the low half-word
  wire        addr_ok  = hsel & hready & htrans[1];
  wire [15:0] a_idx    = haddr[17:2];
  wire        rd_req   = addr_ok & ~hwrite;
  wire        wr_now   = wr_pend_r;
  wire [15:0] wdat     = hwdata[15:0];

  // Read clears the matching resampler full flag
  // Clearing in the address phase lets a poll right after see the flag down
  wire rd_l_hi = rd_req & (a_idx == `AVMR_IDX_RSMP_L_HI);
  wire rd_r_hi = rd_req & (a_idx == `AVMR_IDX_RSMP_R_HI);

  // Timer ticks; compare with >= so that a rate lowered below the running
  // count ends the period at once instead of waiting for the counter to wrap
  wire mix_tick  = mix_ena_r & (mix_cnt_r >= mix_rate_r);
  wire [12:0] rsmp_top = {rsmp_rate_r, 1'b1};
  wire rsmp_tick = rsmp_ena_r & (rsmp_cnt_r >= rsmp_top);
  wire rsmp_ready = (rsmp_seen_r == `AVMR_RSMP_SETTLE);
  wire rsmp_store = rsmp_tick & rsmp_ready;

  // Write strobes in the data phase
  wire wr_mix_cfg  = wr_now & (wr_idx_r == `AVMR_IDX_MIX_CFG);
  wire wr_rsmp_cfg = wr_now & (wr_idx_r == `AVMR_IDX_RSMP_CFG);
  wire wr_mix_lhi  = wr_now & (wr_idx_r == `AVMR_IDX_MIX_L_HI);
  wire wr_mix_rhi  = wr_now & (wr_idx_r == `AVMR_IDX_MIX_R_HI);

  // Full goes up once both high words have been written
  // Low words may be written in any order; only the high words arm the flag
  wire mix_l_done  = mix_l_wr_r | wr_mix_lhi;
  wire mix_r_done  = mix_r_wr_r | wr_mix_rhi;
  wire mix_set_full = mix_l_done & mix_r_done;

  // Read multiplexer
  reg [15:0] rd_val;
  always @* begin
    case (a_idx)
      `AVMR_IDX_VOLUME:    rd_val = volume_r;
      `AVMR_IDX_MIX_CFG:   rd_val = {1'b0, mix_urun_r, mix_full_r, mix_ena_r, mix_rate_r};
      `AVMR_IDX_MIX_L_LO:  rd_val = mix_l_lo_r;
      `AVMR_IDX_MIX_L_HI:  rd_val = mix_l_hi_r;
      `AVMR_IDX_MIX_R_LO:  rd_val = mix_r_lo_r;
      `AVMR_IDX_MIX_R_HI:  rd_val = mix_r_hi_r;
      `AVMR_IDX_RSMP_CFG:  rd_val = {rsmp_orun_r, rsmp_rfull_r, rsmp_lfull_r,
                                     rsmp_ena_r, rsmp_rate_r};
      // Low bytes sit in the upper half of the low word
      `AVMR_IDX_RSMP_L_LO: rd_val = {rsmp_l_out_r[7:0], 8'h00};
      `AVMR_IDX_RSMP_L_HI: rd_val = rsmp_l_out_r[23:8];
      `AVMR_IDX_RSMP_R_LO: rd_val = {rsmp_r_out_r[7:0], 8'h00};
      `AVMR_IDX_RSMP_R_HI: rd_val = rsmp_r_out_r[23:8];
      default:             rd_val = 16'h0000;
    endcase
  end

  // Bus slave: zero wait states, always OKAY, read data in the data phase
  // Ready is held low in reset so nothing is accepted before the registers settle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 16'h0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= addr_ok & hwrite;
      if (addr_ok)
        wr_idx_r <= a_idx;
      // Unmapped or write phases read back zero
      // Data is registered, so it stands for exactly the one data-phase cycle
      hrdata <= rd_req ? {16'h0000, rd_val} : 32'h0000_0000;
    end
  end

  // Volume and mix-in data words: plain storage
  // Resampler data words have no write path: the converter owns them
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      volume_r   <= `AVMR_RESET_VALUE;
      mix_l_lo_r <= `AVMR_RESET_VALUE;
      mix_l_hi_r <= `AVMR_RESET_VALUE;
      mix_r_lo_r <= `AVMR_RESET_VALUE;
      mix_r_hi_r <= `AVMR_RESET_VALUE;
    end else if (wr_now) begin
      case (wr_idx_r)
        `AVMR_IDX_VOLUME:   volume_r   <= wdat;
        `AVMR_IDX_MIX_L_LO: mix_l_lo_r <= wdat;
        `AVMR_IDX_MIX_L_HI: mix_l_hi_r <= wdat;
        `AVMR_IDX_MIX_R_LO: mix_r_lo_r <= wdat;
        `AVMR_IDX_MIX_R_HI: mix_r_hi_r <= wdat;
        default: ;
      endcase
    end
  end

  // Mix-in control: timer, take of new samples, flags and interrupt
  // A rate write does not restart a running period; the new value applies at once
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mix_rate_r  <= 12'h000;
      mix_ena_r   <= 1'b0;
      mix_full_r  <= 1'b0;
      mix_urun_r  <= 1'b0;
      mix_l_wr_r  <= 1'b0;
      mix_r_wr_r  <= 1'b0;
      mix_cnt_r   <= 12'h000;
      mix_l_cur_r <= 20'h0_0000;
      mix_r_cur_r <= 20'h0_0000;
      mix_in_irq  <= 1'b0;
    end else begin
      mix_in_irq <= mix_tick;
      // Config write; a zero written to underrun clears it
      if (wr_mix_cfg) begin
        mix_rate_r <= wdat[`AVMR_CFG_RATE_MSB:0];
        mix_ena_r  <= wdat[`AVMR_CFG_ENA_BIT];
        if (!wdat[`AVMR_CFG_URUN_BIT])
          mix_urun_r <= 1'b0;
      end
      // Period counter restarts while disabled so the first take is one full period out
      if (!mix_ena_r || mix_tick)
        mix_cnt_r <= 12'h000;
      else
        mix_cnt_r <= mix_cnt_r + 12'h001;
      // Track which high words were written since full was last set
      mix_l_wr_r <= mix_l_done & ~mix_set_full;
      mix_r_wr_r <= mix_r_done & ~mix_set_full;
      if (mix_tick) begin
        if (mix_full_r) begin
          mix_l_cur_r <= {mix_l_hi_r, mix_l_lo_r[`AVMR_MIX_LO_MSB:`AVMR_MIX_LO_LSB]};
          mix_r_cur_r <= {mix_r_hi_r, mix_r_lo_r[`AVMR_MIX_LO_MSB:`AVMR_MIX_LO_LSB]};
        end else begin
          // The old sample keeps playing, which is softer than a drop to zero
          mix_urun_r <= 1'b1;
        end
      end
      // Fresh writes win over a take in the same cycle
      if (mix_set_full)
        mix_full_r <= 1'b1;
      else if (mix_tick)
        mix_full_r <= 1'b0;
    end
  end

  // Volume and mix output stage, one cycle after each DAC sample
  wire [23:0] vol_l = apply_volume(dac_left_in,
                        volume_r[`AVMR_VOL_LCOARSE_MSB:`AVMR_VOL_LCOARSE_LSB],
                        volume_r[`AVMR_VOL_LFINE_MSB:`AVMR_VOL_LFINE_LSB]);
  wire [23:0] vol_r = apply_volume(dac_right_in,
                        volume_r[`AVMR_VOL_RCOARSE_MSB:`AVMR_VOL_RCOARSE_LSB],
                        volume_r[`AVMR_VOL_RFINE_MSB:`AVMR_VOL_RFINE_LSB]);
  // Disabled mix-in contributes nothing
  wire [19:0] add_l = mix_ena_r ? mix_l_cur_r : 20'h0_0000;
  wire [19:0] add_r = mix_ena_r ? mix_r_cur_r : 20'h0_0000;
  // Only bits 23:4 of a volumed sample reach the mixer; the low nibble is dropped

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_left_out  <= 20'h0_0000;
      dac_right_out <= 20'h0_0000;
      dac_out_valid <= 1'b0;
    end else begin
      dac_out_valid <= dac_in_valid;
      if (dac_in_valid) begin
        dac_left_out  <= sat_add20(vol_l[23:4], add_l);
        dac_right_out <= sat_add20(vol_r[23:4], add_r);
      end
    end
  end

  // Resampler: holds the newest input and emits it on its own faster grid
  // Zero-order hold only: there is no interpolation filter in this stage
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsmp_rate_r   <= 12'h000;
      rsmp_ena_r    <= 1'b0;
      rsmp_lfull_r  <= 1'b0;
      rsmp_rfull_r  <= 1'b0;
      rsmp_orun_r   <= 1'b0;
      rsmp_l_out_r  <= 24'h00_0000;
      rsmp_r_out_r  <= 24'h00_0000;
      rsmp_cnt_r    <= 13'h0000;
      rsmp_seen_r   <= 5'h00;
      rsmp_l_hold_r <= 24'h00_0000;
      rsmp_r_hold_r <= 24'h00_0000;
      resampler_irq <= 1'b0;
    end else begin
      resampler_irq <= rsmp_store;
      // Config write; a zero written to overrun clears it
      if (wr_rsmp_cfg) begin
        rsmp_rate_r <= wdat[`AVMR_CFG_RATE_MSB:0];
        rsmp_ena_r  <= wdat[`AVMR_CFG_ENA_BIT];
        if (!wdat[`AVMR_CFG_ORUN_BIT])
          rsmp_orun_r <= 1'b0;
      end
      // Both counters restart while disabled, including the settle count
      if (!rsmp_ena_r) begin
        rsmp_cnt_r  <= 13'h0000;
        rsmp_seen_r <= 5'h00;
      end else begin
        rsmp_cnt_r <= rsmp_tick ? 13'h0000 : rsmp_cnt_r + 13'h0001;
        // The count stops at its threshold so it never wraps back to not ready
        if (dac_in_valid && !rsmp_ready)
          rsmp_seen_r <= rsmp_seen_r + 5'h01;
      end
      if (dac_in_valid) begin
        rsmp_l_hold_r <= dac_left_in;
        rsmp_r_hold_r <= dac_right_in;
      end
      if (rsmp_store) begin
        rsmp_l_out_r <= rsmp_l_hold_r;
        rsmp_r_out_r <= rsmp_r_hold_r;
        if (rsmp_lfull_r || rsmp_rfull_r)
          rsmp_orun_r <= 1'b1;
      end
      // Store wins over a read in the same cycle
      // Neither flag is writable: only a read or a new store moves it
      if (rsmp_store)
        rsmp_lfull_r <= 1'b1;
      else if (rd_l_hi)
        rsmp_lfull_r <= 1'b0;
      if (rsmp_store)
        rsmp_rfull_r <= 1'b1;
      else if (rd_r_hi)
        rsmp_rfull_r <= 1'b0;
    end
  end

endmodule

//--- shared/avmr_map.vh
// Register map and field layout of the audio volume, mix-in and resampler block.
// Assumes a 32-bit AHB-Lite bus; each register index maps to byte address 4*index.
`ifndef AVMR_MAP_VH
`define AVMR_MAP_VH

// Register indices (byte address is four times the index)
`define AVMR_IDX_VOLUME       16'hfec0
`define AVMR_IDX_MIX_CFG      16'hfec1
`define AVMR_IDX_MIX_L_LO     16'hfec2
`define AVMR_IDX_MIX_L_HI     16'hfec3
`define AVMR_IDX_MIX_R_LO     16'hfec4
`define AVMR_IDX_MIX_R_HI     16'hfec5
`define AVMR_IDX_RSMP_CFG     16'hfec6
`define AVMR_IDX_RSMP_L_LO    16'hfec7
`define AVMR_IDX_RSMP_L_HI    16'hfed8
`define AVMR_IDX_RSMP_R_LO    16'hfed9
`define AVMR_IDX_RSMP_R_HI    16'hfeda

// Volume register fields
`define AVMR_VOL_LFINE_MSB    15
`define AVMR_VOL_LFINE_LSB    12
`define AVMR_VOL_LCOARSE_MSB  11
`define AVMR_VOL_LCOARSE_LSB  8
`define AVMR_VOL_RFINE_MSB    7
`define AVMR_VOL_RFINE_LSB    4
`define AVMR_VOL_RCOARSE_MSB  3
`define AVMR_VOL_RCOARSE_LSB  0
`define AVMR_FINE_MAX_CODE    4'hb

// Configuration register fields (rate and enable shared by mix-in and resampler; flag bits differ)
`define AVMR_CFG_RATE_MSB     11
`define AVMR_CFG_ENA_BIT      12
`define AVMR_CFG_FULL_BIT     13
`define AVMR_CFG_URUN_BIT     14
`define AVMR_CFG_RFULL_BIT    14
`define AVMR_CFG_ORUN_BIT     15

// Low-word sample fields
`define AVMR_MIX_LO_MSB       15
`define AVMR_MIX_LO_LSB       12
`define AVMR_RSMP_LO_MSB      15
`define AVMR_RSMP_LO_LSB      8

// Resampler start-up: input samples before output counts as valid
`define AVMR_RSMP_SETTLE      5'h13

// Reset value of every register
`define AVMR_RESET_VALUE      16'h0000

`endif

//--- testbench/avmr_asserts.sv
// Port-level checker for the volume, mix-in and resampler block.
// Assumes it is bound to avmr_top and that the register map header is on the include path.
`timescale 1ns/1ps
`include "avmr_map.vh"
module avmr_asserts (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        dac_in_valid,
  input wire [19:0] dac_left_out,
  input wire [19:0] dac_right_out,
  input wire        dac_out_valid,
  input wire        mix_in_irq,
  input wire        resampler_irq
);
  reg  [4:0] in_cnt_r;                                 // Input samples since reset, saturating
  reg        mix_wr_r;                                 // Mix-in config written since reset
  wire       take  = hsel && hready && htrans[1];     // Address phase accepted
  wire       rd_ok = take && !hwrite;                  // Read accepted
  wire       mix_wr = take && hwrite && haddr[17:2] == `AVMR_IDX_MIX_CFG;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Counting from reset bounds the settle count from above; a disable only restarts it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_cnt_r <= 5'h00;
      mix_wr_r <= 1'b0;
    end else begin
      if (dac_in_valid && in_cnt_r != 5'h1f) in_cnt_r <= in_cnt_r + 5'h01;
      if (mix_wr) mix_wr_r <= 1'b1;
    end
  end
  bus_okay_a:
    assert property (hresp == 1'b0) else $error("slave response was not OKAY");
  ready_high_a:
    assert property ($past(hresetn) |-> hreadyout) else $error("slave inserted a wait state");
  rdata_idle_a:
    assert property (!$past(rd_ok) |-> hrdata == 32'h0000_0000) else $error("stale read data");
  rdata_upper_a:
    assert property (hrdata[31:16] == 16'h0000) else $error("upper read half not zero");
  out_latency_a:
    assert property (dac_out_valid == $past(dac_in_valid)) else $error("output strobe not one late");
  out_hold_a:
    assert property (!dac_out_valid |-> $stable(dac_left_out) && $stable(dac_right_out))
      else $error("output sample moved without strobe");
  rsmp_pulse_a:
    assert property (resampler_irq |=> !resampler_irq) else $error("store request too long");
  rsmp_settle_a:
    assert property (resampler_irq |-> in_cnt_r >= 5'h13) else $error("store before settling");
  mix_quiet_a:
    assert property (mix_in_irq |-> mix_wr_r) else $error("mix request while never enabled");
endmodule

//--- testbench/avmr_dac_feed.sv
// Stand-in for the software that refills the DAC sample registers each DAC period.
// Assumes the bench calls send() and the design samples on the rising hclk edge.
`timescale 1ns/1ps
module avmr_dac_feed (
  input  wire        hclk,
  output reg  [23:0] left,
  output reg  [23:0] right,
  output reg         valid
);
  initial begin
    left  = 24'h00_0000;
    right = 24'h00_0000;
    valid = 1'b0;
  end
  // One stereo sample per call after a gap of idle cycles, prompt or slow
  task send(input [23:0] l, input [23:0] r, input integer gap);
    begin
      repeat (gap) @(posedge hclk);
      @(posedge hclk);
      left  <= l;
      right <= r;
      valid <= 1'b1;
      @(posedge hclk);
      valid <= 1'b0;
      // Lines are not held once taken: the inverse exposes any use without the strobe
      left  <= ~l;
      right <= ~r;
    end
  endtask
endmodule

//--- testbench/avmr_top_test.sv
// Self-checking bench: registers over AHB-Lite, DAC stream from the feed model.
// Assumes a zero-wait slave; hready is looped back from hreadyout.
`timescale 1ns/1ps
`include "avmr_map.vh"
module avmr_top_test;
  reg          hclk, hresetn, hsel, hwrite;
  reg  [31:0]  haddr, hwdata, rd;
  reg  [1:0]   htrans;
  reg  [2:0]   hsize;
  wire [31:0]  hrdata;
  wire         hreadyout, hresp, dac_in_valid, dac_out_valid, mix_in_irq, resampler_irq;
  wire [23:0]  dac_left_in, dac_right_in;
  wire [19:0]  dac_left_out, dac_right_out;
  wire [2:0]   sigs = {resampler_irq, mix_in_irq, dac_out_valid}; // Waitable events
  integer      fails, checks_done, t0, i;
  integer      cyc = 0, rsmp_hits = 0;                             // Edge-driven counters
  reg  [103:0] rows [0:4];                                         // vol, in l/r, out l/r
  avmr_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .dac_left_in, .dac_right_in,
    .dac_in_valid, .dac_left_out, .dac_right_out, .dac_out_valid, .mix_in_irq, .resampler_irq);
  avmr_dac_feed dac_u (.hclk, .left(dac_left_in), .right(dac_right_in), .valid(dac_in_valid));
  always #5 hclk = ~hclk;
  // Cycle count and store requests, both read at edges before updates land
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (resampler_irq === 1'b1) rsmp_hits <= rsmp_hits + 1;
  end
  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // One single transfer; the bus never stalls, yet the wait is kept in case it does
  task bus(input w, input [15:0] idx, input [15:0] d);
    begin
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {14'h0000, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {16'h0000, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task wait_on(input integer which, input integer lim);
    integer n;
    begin
      n = 0;
      do begin
        @(posedge hclk);
        n = n + 1;
      end while (n < lim && sigs[which] !== 1'b1);
      check(n < lim, 1, "event wait");
    end
  endtask
  task dac_check(input [23:0] l, input [23:0] r, input [19:0] el, input [19:0] er);
    begin
      dac_u.send(l, r, 0);
      wait_on(0, 4);
      check(dac_left_out, el, "left out");
      check(dac_right_out, er, "right out");
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // Hang guard: the sequence needs about 1100 cycles
  initial begin
    #200000;
    fails = fails + 1;
    close_out;
  end
  initial begin
    {fails, checks_done} = 0;
    {hclk, hresetn, hsel, hwrite, haddr, hwdata, htrans} = 0;
    hsize = 3'b010;
    rows[0] = {16'h0000, 24'h10_0000, 24'hf0_0000, 20'h1_0000, 20'hf_0000};
    rows[1] = {16'h0203, 24'h10_0000, 24'hf0_0000, 20'h0_4000, 20'hf_e000};
    rows[2] = {16'hb0c0, 24'h01_0000, 24'h01_0000, 20'h0_1e23, 20'h0_1000};
    rows[3] = {16'h10f1, 24'h01_0000, 24'h01_0000, 20'h0_10f2, 20'h0_0800};
    rows[4] = {16'h0f00, 24'h7f_ffff, 24'h7f_ffff, 20'h0_000f, 20'h7_ffff};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // All eleven registers, then one unmapped index, read zero
    for (i = 0; i < 12; i = i + 1) begin
      bus(0, i < 8 ? 16'hfec0 + i : i < 11 ? 16'hfed0 + i : 16'hfec8, 0);
      check(rd, 0, "reset read");
    end
    for (i = 0; i < 5; i = i + 1) begin
      bus(1, `AVMR_IDX_VOLUME, rows[i][103:88]);
      bus(0, `AVMR_IDX_VOLUME, 0);
      check(rd, rows[i][103:88], "volume");
      dac_check(rows[i][87:64], rows[i][63:40], rows[i][39:20], rows[i][19:0]);
    end
    bus(1, `AVMR_IDX_VOLUME, 0);
    bus(1, `AVMR_IDX_MIX_L_LO, 16'h5000);
    bus(1, `AVMR_IDX_MIX_L_HI, 16'h0001);
    bus(1, `AVMR_IDX_MIX_R_LO, 16'h0000);
    bus(1, `AVMR_IDX_MIX_R_HI, 16'hffff);
    bus(0, `AVMR_IDX_MIX_CFG, 0);
    check(rd, 32'h0000_2000, "mix full");
    bus(1, `AVMR_IDX_MIX_CFG, 16'h101f);
    wait_on(1, 40);
    t0 = cyc;
    bus(0, `AVMR_IDX_MIX_CFG, 0);
    check(rd, 32'h0000_101f, "mix taken");
    dac_check(24'h00_0000, 24'h00_0000, 20'h0_0015, 20'hf_fff0);
    wait_on(1, 40);
    check(cyc - t0, 32, "mix period");
    bus(0, `AVMR_IDX_MIX_CFG, 0);
    check(rd, 32'h0000_501f, "mix underrun");
    // Both channels pushed past full scale, opposite signs
    bus(1, `AVMR_IDX_MIX_L_LO, 16'hf000);
    bus(1, `AVMR_IDX_MIX_L_HI, 16'h7fff);
    bus(1, `AVMR_IDX_MIX_R_LO, 16'h0000);
    bus(1, `AVMR_IDX_MIX_R_HI, 16'h8000);
    wait_on(1, 40);
    dac_check(24'h7f_fff0, 24'h80_0000, 20'h7_ffff, 20'h8_0000);
    bus(1, `AVMR_IDX_MIX_CFG, 0);
    rd = 0;
    repeat (70) begin
      @(posedge hclk);
      rd = rd | mix_in_irq;
    end
    check(rd, 0, "mix quiet");
    dac_check(24'h00_0100, 24'h00_0100, 20'h0_0010, 20'h0_0010);
    // Resampler: 18 slow samples, then a tick with 18 seen; a store there is premature
    bus(1, `AVMR_IDX_RSMP_CFG, 16'h103f);
    t0 = rsmp_hits;
    for (i = 0; i < 18; i = i + 1) dac_u.send(24'h00_0011, 24'h00_0022, 6);
    repeat (120) @(posedge hclk);
    check(rsmp_hits - t0, 0, "settle");
    dac_u.send(24'h12_3456, 24'hab_cdef, 0);
    wait_on(2, 140);
    t0 = cyc;
    bus(0, `AVMR_IDX_RSMP_CFG, 0);
    check(rd, 32'h0000_703f, "rsmp full");
    bus(0, `AVMR_IDX_RSMP_L_HI, 0);
    check(rd, 32'h0000_1234, "rsmp left hi");
    bus(0, `AVMR_IDX_RSMP_L_LO, 0);
    check(rd, 32'h0000_5600, "rsmp left lo");
    bus(0, `AVMR_IDX_RSMP_R_LO, 0);
    check(rd, 32'h0000_ef00, "rsmp right lo");
    bus(0, `AVMR_IDX_RSMP_CFG, 0);
    check(rd, 32'h0000_503f, "left read");
    wait_on(2, 140);
    check(cyc - t0, 128, "rsmp period");
    bus(0, `AVMR_IDX_RSMP_CFG, 0);
    check(rd, 32'h0000_f03f, "overrun");
    bus(1, `AVMR_IDX_RSMP_CFG, 0);
    t0 = rsmp_hits;
    repeat (300) @(posedge hclk);
    check(rsmp_hits - t0, 0, "rsmp off");
    // Reset in mid-run clears a written register
    bus(1, `AVMR_IDX_VOLUME, 16'h1234);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(0, `AVMR_IDX_VOLUME, 0);
    check(rd, 0, "volume after reset");
    close_out;
  end
endmodule
bind avmr_top avmr_asserts chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .dac_in_valid, .dac_left_out, .dac_right_out, .dac_out_valid,
  .mix_in_irq, .resampler_irq);
